// ==== src/tdm_context_pkg.sv ====
// constants for the tdm context control block
package tdm_context_pkg;
   // lookup table and context sizes
   localparam int SLOT_BITS  = 8;
   localparam int SLOT_COUNT = 256;
   localparam int CTX_BITS   = 7;
   localparam int CTX_COUNT  = 128;
   localparam int JB_BITS    = 2;
   localparam int JB_DEPTH   = 4;
   // frame timing: 125 us frames at a 10 ns clock
   localparam int CLK_PERIOD_NS  = 10;
   localparam int FRAME_US       = 125;
   localparam int FRAME_CYCLES   = FRAME_US * 1000 / CLK_PERIOD_NS;
   localparam int SLOT_CNT_BITS  = 14;
   // register byte offsets
   localparam logic [7:0] REG_LUT_INDEX = 8'h00;
   localparam logic [7:0] REG_LUT_ENTRY = 8'h04;
   localparam logic [7:0] REG_CTX_INDEX = 8'h08;
   localparam logic [7:0] REG_CTX_CTRL  = 8'h0c;
   localparam logic [7:0] REG_JB_DELAY  = 8'h10;
   localparam logic [7:0] REG_FILL      = 8'h14;
   localparam logic [7:0] REG_POINTER   = 8'h18;
   // lookup entry field positions
   localparam int F_ID_LSB     = 0;
   localparam int F_ACTIVE     = 8;
   localparam int F_ACTIVE_NXT = 9;
   localparam int F_LEAD       = 10;
   localparam int F_LEAD_NXT   = 11;
   // context control and fill register field positions
   localparam int F_UPDATE   = 0;
   localparam int F_TEARDOWN = 1;
   localparam int F_SWITCH   = 2;
   localparam int F_STARTED  = 3;
   localparam int F_STARVED  = 4;
   localparam int F_FILL_MODE = 8;
   // reset values and response codes
   localparam logic [7:0] RST_JB_DELAY  = 8'h01;
   localparam logic [7:0] RST_FILL_BYTE = 8'hff;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;
   // per-context sequencing of update and teardown
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_ARMED = 2'b01,
      SEQ_RUN   = 2'b10
   } seq_e;
endpackage

// ==== src/tdm_context_control.sv ====
// context lookup, update, teardown and jitter buffer control
`timescale 1ns/1ns
module tdm_context_control #(
   parameter int frame_cycles = tdm_context_pkg::FRAME_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  tdm_in,
   output logic [7:0]       tdm_out,
   output logic             pkt_valid,
   output logic [7:0]       pkt_data,
   output logic [6:0]       pkt_context,
   output logic             pkt_switch,
   output logic             pkt_frame_end,
   input  wire logic        eg_valid,
   input  wire logic [6:0]  eg_context,
   input  wire logic [7:0]  eg_slot,
   input  wire logic [7:0]  eg_data,
   input  wire logic        eg_last
);
   localparam int SLOT_CYCLES = frame_cycles / tdm_context_pkg::SLOT_COUNT;
   localparam logic [13:0] SLOT_LAST = 14'(SLOT_CYCLES - 1);

   // lookup table
   logic [6:0]  lut_id    [tdm_context_pkg::SLOT_COUNT];
   logic        lut_act   [tdm_context_pkg::SLOT_COUNT];
   logic        lut_nact  [tdm_context_pkg::SLOT_COUNT];
   logic        lut_lead  [tdm_context_pkg::SLOT_COUNT];
   logic        lut_nlead [tdm_context_pkg::SLOT_COUNT];
   // context memory
   logic        upd_req   [tdm_context_pkg::CTX_COUNT];
   logic        td_req    [tdm_context_pkg::CTX_COUNT];
   logic        sw_flag   [tdm_context_pkg::CTX_COUNT];
   logic [7:0]  first_slot[tdm_context_pkg::CTX_COUNT];
   tdm_context_pkg::seq_e upd_st [tdm_context_pkg::CTX_COUNT];
   tdm_context_pkg::seq_e td_st  [tdm_context_pkg::CTX_COUNT];
   // jitter buffer state
   logic [7:0]  jb_mem
                [tdm_context_pkg::SLOT_COUNT*tdm_context_pkg::JB_DEPTH];
   logic [7:0]  last_val  [tdm_context_pkg::SLOT_COUNT];
   logic [2:0]  wr_ptr    [tdm_context_pkg::CTX_COUNT];
   logic [2:0]  rd_ptr    [tdm_context_pkg::CTX_COUNT];
   logic [7:0]  hold_cnt  [tdm_context_pkg::CTX_COUNT];
   logic        started   [tdm_context_pkg::CTX_COUNT];
   logic        playing   [tdm_context_pkg::CTX_COUNT];
   logic        starved   [tdm_context_pkg::CTX_COUNT];

   logic [13:0] slot_cnt;
   logic        tick;
   logic [7:0]  ptr;
   logic [7:0]  tdm_in_meta;
   logic [7:0]  tdm_in_sync;
   logic [7:0]  lut_index;
   logic [6:0]  ctx_index;
   logic [7:0]  jb_delay;
   logic [7:0]  fill_byte;
   logic        fill_mode;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;

   // combinational view of the slot being served
   logic [6:0]  c;
   logic        copy_now;
   logic        wrap_now;
   logic        act_now;
   logic        tear_now;
   logic        consume;
   logic [2:0]  rd_eff;
   logic        avail;
   logic        play_now;
   logic        hold_done;

   function automatic logic [31:0] lut_word(input logic [7:0] i);
      lut_word = '0;
      lut_word[tdm_context_pkg::F_ID_LSB +: 7] = lut_id[i];
      lut_word[tdm_context_pkg::F_ACTIVE]      = lut_act[i];
      lut_word[tdm_context_pkg::F_ACTIVE_NXT]  = lut_nact[i];
      lut_word[tdm_context_pkg::F_LEAD]        = lut_lead[i];
      lut_word[tdm_context_pkg::F_LEAD_NXT]    = lut_nlead[i];
   endfunction

   // pin input, two flops before use
   always_ff @(posedge aclk) begin
      tdm_in_meta <= tdm_in;
      tdm_in_sync <= tdm_in_meta;
   end

   // constant-rate timeslot pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_cnt <= '0;
         tick     <= 1'b0;
         ptr      <= '0;
      end else begin
         tick <= (slot_cnt == SLOT_LAST);
         if (slot_cnt == SLOT_LAST) begin
            slot_cnt <= '0;
         end else begin
            slot_cnt <= slot_cnt + 14'd1;
         end
         if (tick) begin
            ptr <= ptr + 8'd1;
         end
      end
   end

   always_comb begin
      c         = lut_id[ptr];
      copy_now  = (upd_st[c] == tdm_context_pkg::SEQ_ARMED && lut_nlead[ptr])
                  || (upd_st[c] == tdm_context_pkg::SEQ_RUN
                      && ptr != first_slot[c]);
      wrap_now  = upd_st[c] == tdm_context_pkg::SEQ_RUN
                  && ptr == first_slot[c];
      act_now   = copy_now ? lut_nact[ptr] : lut_act[ptr];
      tear_now  = td_st[c] == tdm_context_pkg::SEQ_RUN;
      consume   = lut_lead[ptr] && playing[c];
      rd_eff    = rd_ptr[c] + {2'b00, consume};
      avail     = wr_ptr[c] != rd_eff;
      hold_done = hold_cnt[c] >= jb_delay;
      if (!lut_lead[ptr]) begin
         play_now = playing[c];
      end else if (started[c]) begin
         play_now = avail;
      end else begin
         play_now = avail && hold_done;
      end
   end

   // lookup table: host writes, update copies and teardown clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < tdm_context_pkg::SLOT_COUNT; i++) begin
            lut_id[i]    <= '0;
            lut_act[i]   <= 1'b0;
            lut_nact[i]  <= 1'b0;
            lut_lead[i]  <= 1'b0;
            lut_nlead[i] <= 1'b0;
         end
      end else begin
         if (wr_go && aw_addr == tdm_context_pkg::REG_LUT_ENTRY) begin
            lut_id[lut_index]    <= w_data[tdm_context_pkg::F_ID_LSB +: 7];
            lut_act[lut_index]   <= w_data[tdm_context_pkg::F_ACTIVE];
            lut_nact[lut_index]  <= w_data[tdm_context_pkg::F_ACTIVE_NXT];
            lut_lead[lut_index]  <= w_data[tdm_context_pkg::F_LEAD];
            lut_nlead[lut_index] <= w_data[tdm_context_pkg::F_LEAD_NXT];
         end
         if (tick && tear_now) begin
            lut_act[ptr]   <= 1'b0;
            lut_nact[ptr]  <= 1'b0;
            lut_lead[ptr]  <= 1'b0;
            lut_nlead[ptr] <= 1'b0;
         end else if (tick && copy_now) begin
            lut_act[ptr]  <= lut_nact[ptr];
            lut_lead[ptr] <= lut_nlead[ptr];
         end
      end
   end

   // context memory: update and teardown sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < tdm_context_pkg::CTX_COUNT; i++) begin
            upd_req[i]    <= 1'b0;
            td_req[i]     <= 1'b0;
            sw_flag[i]    <= 1'b0;
            first_slot[i] <= '0;
            upd_st[i]     <= tdm_context_pkg::SEQ_IDLE;
            td_st[i]      <= tdm_context_pkg::SEQ_IDLE;
         end
      end else begin
         if (tick && ptr == 8'h00) begin
            for (int i = 0; i < tdm_context_pkg::CTX_COUNT; i++) begin
               // arm only at a frame boundary
               if (upd_st[i] == tdm_context_pkg::SEQ_IDLE && upd_req[i]) begin
                  upd_st[i] <= tdm_context_pkg::SEQ_ARMED;
               end
               if (td_st[i] == tdm_context_pkg::SEQ_RUN) begin
                  td_st[i]  <= tdm_context_pkg::SEQ_IDLE;
                  td_req[i] <= 1'b0;
               end else if (td_req[i]) begin
                  td_st[i] <= tdm_context_pkg::SEQ_RUN;
               end
            end
         end
         if (tick && upd_st[c] == tdm_context_pkg::SEQ_ARMED
             && lut_nlead[ptr]) begin
            upd_st[c]     <= tdm_context_pkg::SEQ_RUN;
            first_slot[c] <= ptr;
         end
         if (tick && wrap_now) begin
            upd_st[c]  <= tdm_context_pkg::SEQ_IDLE;
            upd_req[c] <= 1'b0;
            sw_flag[c] <= ~sw_flag[c];
         end
         // host sets win over hardware clears
         if (wr_go && aw_addr == tdm_context_pkg::REG_CTX_CTRL) begin
            if (w_data[tdm_context_pkg::F_UPDATE]) begin
               upd_req[ctx_index] <= 1'b1;
            end
            if (w_data[tdm_context_pkg::F_TEARDOWN]) begin
               td_req[ctx_index] <= 1'b1;
            end
         end
      end
   end

   // receive side payload stream
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pkt_valid     <= 1'b0;
         pkt_data      <= '0;
         pkt_context   <= '0;
         pkt_switch    <= 1'b0;
         pkt_frame_end <= 1'b0;
      end else begin
         pkt_valid     <= tick && act_now;
         pkt_frame_end <= tick && ptr == 8'hff;
         if (tick) begin
            pkt_data    <= tdm_in_sync;
            pkt_context <= c;
            pkt_switch  <= wrap_now ? ~sw_flag[c] : sw_flag[c];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (eg_valid) begin
         jb_mem[{eg_slot, wr_ptr[eg_context][1:0]}] <= eg_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < tdm_context_pkg::CTX_COUNT; i++) begin
            wr_ptr[i]   <= '0;
            rd_ptr[i]   <= '0;
            hold_cnt[i] <= '0;
            started[i]  <= 1'b0;
            playing[i]  <= 1'b0;
            starved[i]  <= 1'b0;
         end
      end else begin
         // full queue holds wr_ptr, but the arriving bytes still overwrite the entry at rd_ptr
         if (eg_valid && eg_last
             && (wr_ptr[eg_context] - rd_ptr[eg_context]) != 3'd4) begin
            wr_ptr[eg_context] <= wr_ptr[eg_context] + 3'd1;
         end
         if (tick && lut_lead[ptr]) begin
            rd_ptr[c]  <= rd_eff;
            playing[c] <= play_now;
            if (!started[c]) begin
               if (avail && hold_done) begin
                  started[c] <= 1'b1;
               end else if (avail) begin
                  hold_cnt[c] <= hold_cnt[c] + 8'd1;
               end
            end else begin
               starved[c] <= !avail;
            end
         end
         if (tick && tear_now) begin
            started[c]  <= 1'b0;
            hold_cnt[c] <= '0;
         end
      end
   end

   // transmit playout
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tdm_out <= tdm_context_pkg::RST_FILL_BYTE;
         for (int i = 0; i < tdm_context_pkg::SLOT_COUNT; i++) begin
            last_val[i] <= tdm_context_pkg::RST_FILL_BYTE;
         end
      end else if (tick && lut_act[ptr]) begin
         if (play_now) begin
            tdm_out       <= jb_mem[{ptr, rd_eff[1:0]}];
            last_val[ptr] <= jb_mem[{ptr, rd_eff[1:0]}];
         end else begin
            tdm_out <= fill_mode ? fill_byte : last_val[ptr];
         end
      end
   end

   // axi4-lite slave; address and data taken in either order
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tdm_context_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready  <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_addr > tdm_context_pkg::REG_POINTER
                            ? tdm_context_pkg::RESP_SLVERR
                            : tdm_context_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // simple registers; writes land only with all four strobes set, partial-strobe writes are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lut_index <= '0;
         ctx_index <= '0;
         jb_delay  <= tdm_context_pkg::RST_JB_DELAY;
         fill_byte <= tdm_context_pkg::RST_FILL_BYTE;
         fill_mode <= 1'b0;
      end else if (wr_go && w_strb == 4'hf) begin
         case (aw_addr)
            tdm_context_pkg::REG_LUT_INDEX: lut_index <= w_data[7:0];
            tdm_context_pkg::REG_CTX_INDEX: ctx_index <= w_data[6:0];
            tdm_context_pkg::REG_JB_DELAY:  jb_delay  <= w_data[7:0];
            tdm_context_pkg::REG_FILL: begin
               fill_byte <= w_data[7:0];
               fill_mode <= w_data[tdm_context_pkg::F_FILL_MODE];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= tdm_context_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tdm_context_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            case ({s_axi_araddr[7:2], 2'b00})
               tdm_context_pkg::REG_LUT_INDEX: s_axi_rdata[7:0] <= lut_index;
               tdm_context_pkg::REG_LUT_ENTRY:
                  s_axi_rdata <= lut_word(lut_index);
               tdm_context_pkg::REG_CTX_INDEX: s_axi_rdata[6:0] <= ctx_index;
               tdm_context_pkg::REG_CTX_CTRL: s_axi_rdata[4:0] <= {
                  starved[ctx_index], started[ctx_index],
                  sw_flag[ctx_index], td_req[ctx_index],
                  upd_req[ctx_index]};
               tdm_context_pkg::REG_JB_DELAY: s_axi_rdata[7:0] <= jb_delay;
               tdm_context_pkg::REG_FILL:
                  s_axi_rdata[8:0] <= {fill_mode, fill_byte};
               tdm_context_pkg::REG_POINTER: s_axi_rdata[7:0] <= ptr;
               default: s_axi_rresp <= tdm_context_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ==== verification/tdm_context_chk.sv ====
// port checker for the tdm context control block
`timescale 1ns/1ns
module tdm_context_chk #(
   parameter int frame_cycles = 12500
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        pkt_valid,
   input wire logic        pkt_frame_end
);
   // the slot tick truncates, so a frame is a whole number of ticks
   localparam int FRAME_LEN = (frame_cycles / 256) * 256;
   logic [15:0] gap;
   logic        seen;
   always_ff @(posedge aclk) begin
      if (!aresetn || pkt_frame_end) begin
         gap <= 16'h0;
      end else begin
         gap <= gap + 16'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen <= 1'b0;
      end else if (pkt_frame_end) begin
         seen <= 1'b1;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // halves are held one cycle before the response is launched
   a_write_resp: assert property (
      wr_taken |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_bresp_code: assert property (
      s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("bad write response code");
   a_read_resp: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answering");
   a_slot_pace: assert property (pkt_valid |=> !pkt_valid [*8])
      else $error("more than one byte per slot");
   a_frame_len: assert property (
      pkt_frame_end && seen |-> int'(gap) == FRAME_LEN - 1)
      else $error("frame length wrong");
endmodule

// ==== verification/tdm_far_end.sv ====
// far side model: tdm line source and egress packet source
`timescale 1ns/1ns
module tdm_far_end (
   input  wire logic  aclk,
   output logic [7:0] tdm_in,
   output logic       eg_valid,
   output logic [6:0] eg_context,
   output logic [7:0] eg_slot,
   output logic [7:0] eg_data,
   output logic       eg_last
);
   logic [23:0] q[$];
   initial begin
      tdm_in = 8'h0;
      eg_valid = 1'b0;
      {eg_last, eg_context, eg_slot, eg_data} = 24'h0;
   end
   task automatic send(input logic [6:0] c, input logic [7:0] a, b);
      q.push_back({1'b0, c, a, 8'h11});
      q.push_back({1'b1, c, b, 8'h22});
   endtask
   // idle lines keep moving so stale bytes never look valid
   always @(posedge aclk) begin
      tdm_in <= tdm_in + 8'h3b;
      eg_valid <= q.size() > 0;
      if (q.size() > 0) begin
         {eg_last, eg_context, eg_slot, eg_data} <= q.pop_front();
      end else begin
         eg_last <= 1'b0;
         eg_slot <= eg_slot + 8'h1;
         eg_data <= ~eg_data;
      end
   end
endmodule

// ==== verification/tdm_context_control_tb.sv ====
// self-checking bench for the tdm context control block
`timescale 1ns/1ns
module tdm_context_control_tb;
   localparam int FC = 2560;
   localparam logic [7:0] LIX = tdm_context_pkg::REG_LUT_INDEX;
   localparam logic [7:0] LEN = tdm_context_pkg::REG_LUT_ENTRY;
   localparam logic [7:0] LCI = tdm_context_pkg::REG_CTX_INDEX;
   localparam logic [7:0] LCC = tdm_context_pkg::REG_CTX_CTRL;
   localparam logic [7:0] LJB = tdm_context_pkg::REG_JB_DELAY;
   localparam logic [7:0] LFI = tdm_context_pkg::REG_FILL;
   typedef struct {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } exp_s;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pkt_valid;
   logic        pkt_switch, pkt_frame_end, eg_valid, eg_last;
   logic [7:0]  tdm_in, tdm_out, pkt_data, eg_slot, eg_data, s0, s1;
   logic [6:0]  pkt_context, eg_context, ctx;
   logic [7:0]  h1, h2, h3;
   logic        last_sw = 1'b0;
   int          n_errors = 0, tests_run = 0, cnt = 0, last_cnt = 0;
   exp_s        rq[$];
   logic [1:0]  bq[$];
   exp_s        e;
   tdm_context_control #(.frame_cycles(FC)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tdm_in, .tdm_out, .pkt_valid,
      .pkt_data, .pkt_context, .pkt_switch, .pkt_frame_end, .eg_valid,
      .eg_context, .eg_slot, .eg_data, .eg_last
   );
   tdm_far_end far_u (
      .aclk, .tdm_in, .eg_valid, .eg_context, .eg_slot, .eg_data, .eg_last
   );
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = 2'b00);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // late ready lets the response stand a few cycles
      repeat ($urandom % 3) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffffffff,
                     input logic [1:0] r = 2'b00);
      rq.push_back('{d, m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom % 3) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic lut(input logic [7:0] s, input logic [11:0] v);
      wr(LIX, {24'h0, s});
      wr(LEN, {20'h0, v});
   endtask
   task automatic lut_chk(input logic [7:0] s, input logic [11:0] v, m);
      wr(LIX, {24'h0, s});
      rd(LEN, {20'h0, v}, {20'h0, m});
   endtask
   task automatic frames(input int n);
      repeat (n * FC) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk(s_axi_rdata & e.m, e.d, "read data");
         chk({30'h0, s_axi_rresp}, {30'h0, e.r}, "read resp");
      end
      if (s_axi_bvalid && s_axi_bready) begin
         e.r = bq.pop_front();
         chk({30'h0, s_axi_bresp}, {30'h0, e.r}, "wr resp");
      end
      // line byte reaches the payload three edges after it is sampled
      if (pkt_valid) begin
         chk({24'h0, pkt_data}, {24'h0, h3}, "payload byte");
      end
      h3 = h2;
      h2 = h1;
      h1 = tdm_in;
      if (pkt_frame_end) begin
         last_cnt = cnt;
         cnt = 0;
      end else if (pkt_valid && pkt_context === ctx) begin
         cnt++;
         last_sw = pkt_switch;
      end
   end
   initial begin
      void'($urandom(32'h1fa5));
      ctx = 7'($urandom % 128);
      s0 = 8'(8 + $urandom % 100);
      s1 = 8'(s0 + 1 + $urandom % 100);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(LJB, 32'h1);
      rd(LFI, 32'hff, 32'h1ff);
      rd(8'h1c, 32'h0, 32'h0, 2'b10);
      wr(8'h1c, 32'h0, 2'b10);
      lut(s0, {4'ha, 1'b0, ctx});
      lut(s1, {4'h2, 1'b1, ctx});
      lut_chk(s0, {4'ha, 1'b0, ctx}, 12'hfff);
      // far end idle and ready first
      wr(LCI, {25'h0, ctx});
      wr(LCC, 32'h1);
      frames(3);
      lut_chk(s0, {4'hf, 1'b0, ctx}, 12'hfff);
      lut_chk(s1, {4'h3, 1'b0, ctx}, 12'hfff);
      rd(LCC, 32'h4, 32'h5);
      chk(32'(last_cnt), 32'h2, "bytes per frame");
      chk({31'h0, last_sw}, 32'h1, "switch after setup");
      wr(LJB, 32'h2);
      // partial strobe must leave the delay alone
      s_axi_wstrb <= 4'h1;
      wr(LJB, 32'h7);
      s_axi_wstrb <= 4'hf;
      rd(LJB, 32'h2);
      wr(LFI, 32'h1a5);
      far_u.send(ctx, s0, s1);
      far_u.send(ctx, s0, s1);
      rd(LCC, 32'h0, 32'h8);
      frames(3);
      rd(LCC, 32'h8, 32'h8);
      frames(6);
      rd(LCC, 32'h10, 32'h10);
      chk({24'h0, tdm_out}, 32'ha5, "fill byte");
      // drop the second slot, current flags left alone
      lut(s1, {4'h1, 1'b0, ctx});
      wr(LCC, 32'h1);
      frames(3);
      lut_chk(s1, 12'h0, 12'hf00);
      rd(LCC, 32'h0, 32'h5);
      chk(32'(last_cnt), 32'h1, "bytes after delete");
      chk({31'h0, last_sw}, 32'h0, "switch after delete");
      lut(s1, {4'h2, 1'b0, ctx});
      wr(LCC, 32'h1);
      frames(3);
      lut_chk(s1, {4'h3, 1'b0, ctx}, 12'hfff);
      chk(32'(last_cnt), 32'h2, "bytes after add");
      chk({31'h0, last_sw}, 32'h1, "switch after add");
      wr(LCC, 32'h2);
      frames(3);
      lut_chk(s0, 12'h0, 12'hf00);
      chk(32'(last_cnt), 32'h0, "bytes after teardown");
      final_report;
   end
   initial begin
      repeat (90000) @(posedge aclk);
      n_errors++;
      final_report;
   end
endmodule
bind tdm_context_control tdm_context_chk #(
   .frame_cycles(frame_cycles)
) chk_u (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .pkt_valid, .pkt_frame_end
);
